/* src/acs_seq_top.v */
// ADC conversion sequencer: APB registers, mode control and result placement
`default_nettype none
`include "acs_map.vh"

module acs_seq_top (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Converter core
	output wire converter_power,
	output reg [3:0] conv_channel,
	output wire conv_clk_tick,
	output wire conv_sampling,
	output wire conv_trigger,
	input wire [11:0] core_result,
	input wire core_valid
);

	// ****************************************
	// Functions
	// ****************************************
	function reg_hit;
		input [7:0] a;
		begin
			reg_hit = (a[1:0] == 2'b00) &&
				((a <= `ACS_OFF_SLOT3) || (a[7:6] == `ACS_BUF_BASE_HI));
		end
	endfunction

	function [15:0] place;
		input [11:0] r;
		input len10;
		input just;
		reg [11:0] v;
		begin
			v = len10 ? {2'b00, r[11:2]} : r;
			if (just) begin
				place = {4'h0, v};
			end else if (len10) begin
				place = {v[9:2], 6'h00, v[1:0]};
			end else begin
				place = {v[11:4], 4'h0, v[3:0]};
			end
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	reg conv_on;
	reg conv_start;
	reg conv_done_flag;
	reg [3:0] ctrl0_misc;
	reg [1:0] int_channel;
	reg [3:0] ext_channel_choice;
	reg [7:0] converter_ctrl2;
	reg [7:0] result_low;
	reg [7:0] result_high;
	reg [7:0] seq_mode_ctrl;
	reg [31:0] sweep_slot_regs;
	reg [2:0] run_idx;
	reg launch;
	reg ack;

	wire result_length = converter_ctrl2[`ACS_CTRL2_LEN];
	wire justify = converter_ctrl2[`ACS_CTRL2_JUST];
	wire buf_mode = seq_mode_ctrl[`ACS_MODE_BUF];
	wire repeat_mode = seq_mode_ctrl[`ACS_MODE_REP];
	wire scan_mode = seq_mode_ctrl[`ACS_MODE_SCAN];
	wire sweep_sample_time = seq_mode_ctrl[`ACS_MODE_SMP];
	wire [2:0] run_last = seq_mode_ctrl[2:0];
	wire buffered = scan_mode | (buf_mode & repeat_mode);

	wire cu_done;
	wire [11:0] cu_result;
	wire [15:0] mem_rd;
	wire [15:0] placed = place(cu_result, result_length, justify);

	// ****************************************
	// APB handshake: one wait state
	// ****************************************
	wire xfer = psel & penable & ack;
	wire wr = xfer & pwrite;
	wire wr_ctrl0 = wr & (paddr == `ACS_OFF_CTRL0);
	wire stop_req = wr_ctrl0 & (~pwdata[`ACS_CTRL0_ON] | ~pwdata[`ACS_CTRL0_START]);
	wire abort = stop_req | ~conv_on;
	wire take = cu_done & ~stop_req;
	wire mem_we = take & buffered;

	assign pready = penable & ack;
	assign pslverr = pready & ~reg_hit(paddr);
	assign converter_power = conv_on;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack <= 1'b0;
		end else begin
			ack <= psel & penable & ~ack;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	reg [7:0] rd_byte;
	always @* begin
		rd_byte = 8'h00;
		case (paddr)
			`ACS_OFF_CTRL0: rd_byte = {conv_on, conv_start, conv_done_flag, 1'b0, ctrl0_misc};
			`ACS_OFF_CHAN: rd_byte = {int_channel, 2'b00, ext_channel_choice};
			`ACS_OFF_CTRL2: rd_byte = converter_ctrl2;
			`ACS_OFF_RES_LOW: rd_byte = result_low;
			`ACS_OFF_RES_HIGH: rd_byte = result_high;
			`ACS_OFF_MODE: rd_byte = seq_mode_ctrl;
			`ACS_OFF_SLOT0: rd_byte = sweep_slot_regs[7:0];
			`ACS_OFF_SLOT1: rd_byte = sweep_slot_regs[15:8];
			`ACS_OFF_SLOT2: rd_byte = sweep_slot_regs[23:16];
			`ACS_OFF_SLOT3: rd_byte = sweep_slot_regs[31:24];
			default: begin
				if (reg_hit(paddr)) begin
					rd_byte = paddr[2] ? mem_rd[7:0] : mem_rd[15:8];
				end
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel & penable & ~ack & ~pwrite) begin
			prdata <= {24'h000000, rd_byte};
		end
	end

	// ****************************************
	// Control, configuration and sequencing
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_on <= 1'b0;
			conv_start <= 1'b0;
			conv_done_flag <= 1'b0;
			ctrl0_misc <= 4'h0;
			int_channel <= 2'b00;
			ext_channel_choice <= 4'h0;
			converter_ctrl2 <= `ACS_RST_BYTE;
			result_low <= `ACS_RST_BYTE;
			result_high <= `ACS_RST_BYTE;
			seq_mode_ctrl <= `ACS_RST_BYTE;
			sweep_slot_regs <= 32'h00000000;
			run_idx <= 3'h0;
			launch <= 1'b0;
		end else begin
			launch <= 1'b0;
			if (wr_ctrl0) begin
				conv_on <= pwdata[`ACS_CTRL0_ON];
				ctrl0_misc <= pwdata[3:0];
				if (!pwdata[`ACS_CTRL0_FLAG]) begin
					conv_done_flag <= 1'b0;
				end
				if (stop_req) begin
					conv_start <= 1'b0;
				end else if (!conv_start && !conv_done_flag) begin
					conv_start <= 1'b1;
					run_idx <= 3'h0;
					launch <= 1'b1;
				end
			end else if (!conv_on) begin
				conv_start <= 1'b0;
			end
			if (wr) begin
				case (paddr)
					`ACS_OFF_CHAN: begin
						int_channel <= pwdata[7:6];
						ext_channel_choice <= pwdata[3:0];
					end
					`ACS_OFF_CTRL2: converter_ctrl2 <= pwdata[7:0];
					`ACS_OFF_RES_LOW: result_low <= pwdata[7:0];
					`ACS_OFF_RES_HIGH: result_high <= pwdata[7:0];
					`ACS_OFF_MODE: seq_mode_ctrl <= pwdata[7:0];
					`ACS_OFF_SLOT0: sweep_slot_regs[7:0] <= pwdata[7:0];
					`ACS_OFF_SLOT1: sweep_slot_regs[15:8] <= pwdata[7:0];
					`ACS_OFF_SLOT2: sweep_slot_regs[23:16] <= pwdata[7:0];
					`ACS_OFF_SLOT3: sweep_slot_regs[31:24] <= pwdata[7:0];
					default: begin
					end
				endcase
			end
			if (take && conv_on) begin
				if (buffered) begin
					if (run_idx == run_last) begin
						run_idx <= 3'h0;
						conv_done_flag <= 1'b1;
						if (scan_mode && repeat_mode) begin
							launch <= 1'b1;
						end else begin
							conv_start <= 1'b0;
						end
					end else begin
						run_idx <= run_idx + 3'h1;
						launch <= 1'b1;
					end
				end else begin
					result_high <= placed[15:8];
					result_low <= placed[7:0];
					conv_done_flag <= 1'b1;
					if (repeat_mode) begin
						launch <= 1'b1;
					end else begin
						conv_start <= 1'b0;
					end
				end
			end
		end
	end

	// Channel for the conversion being launched
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_channel <= 4'h0;
		end else if (launch) begin
			conv_channel <= scan_mode ? sweep_slot_regs[run_idx * 4 +: 4]
				: ext_channel_choice;
		end
	end

	// ****************************************
	// Submodules
	// ****************************************
	acs_conv_unit u_conv (
		.pclk(pclk),
		.presetn(presetn),
		.go(launch),
		.abort(abort),
		.long_sample(scan_mode & sweep_sample_time),
		.busy(),
		.done(cu_done),
		.result(cu_result),
		.conv_clk_tick(conv_clk_tick),
		.sampling(conv_sampling),
		.conv_trigger(conv_trigger),
		.core_result(core_result),
		.core_valid(core_valid)
	);

	acs_buf_mem u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(mem_we),
		.wr_addr(run_idx),
		.wr_data(placed),
		.rd_addr(paddr[5:3]),
		.rd_data(mem_rd)
	);

endmodule // acs_seq_top

`default_nettype wire

/* include/acs_map.vh */
// Register map, field positions and timing counts of the ADC conversion sequencer
// What this block does
// - Justify 0: top eight high, rest low
// - Justify 1: top bits at low end of high byte, low eight low
// - Completion sets flag, clears start unless a repeat restarts; software clears
// - Scan sample time two or thirty-two ticks
// - Run count: conversions, or channels when scanning
// - Repeat mode, buffer bit clear, flags and restarts each conversion
// - Single scan sweeps slots into buffer once
// - Converter off stops a running scan
// - Repeat scan flags each pass, then rescans
// - Start ignored while completion flag set
// - Length bit selects twelve or upper ten
// - Eight four-bit slots, two per register
// - Eight buffer entries, high and low bytes
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define ACS_OFF_CTRL0 8'h00
`define ACS_OFF_CHAN 8'h04
`define ACS_OFF_CTRL2 8'h08
`define ACS_OFF_RES_LOW 8'h0C
`define ACS_OFF_RES_HIGH 8'h10
`define ACS_OFF_MODE 8'h14
`define ACS_OFF_SLOT0 8'h18
`define ACS_OFF_SLOT1 8'h1C
`define ACS_OFF_SLOT2 8'h20
`define ACS_OFF_SLOT3 8'h24
`define ACS_BUF_BASE_HI 2'h1

// ****************************************
// Field positions
// ****************************************
`define ACS_CTRL0_ON 7
`define ACS_CTRL0_START 6
`define ACS_CTRL0_FLAG 5
`define ACS_CTRL2_LEN 7
`define ACS_CTRL2_JUST 6
`define ACS_MODE_BUF 6
`define ACS_MODE_REP 5
`define ACS_MODE_SCAN 4
`define ACS_MODE_SMP 3

// ****************************************
// Reset values and timing counts
// ****************************************
`define ACS_RST_BYTE 8'h00
`define ACS_CLK_DIV 4'h4
`define ACS_SAMPLE_SHORT 6'h02
`define ACS_SAMPLE_LONG 6'h20

`endif

/* src/acs_buf_mem.v */
// Eight-entry result buffer with registered read data
`default_nettype none

module acs_buf_mem (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Write port
	input wire wr_en,
	input wire [2:0] wr_addr,
	input wire [15:0] wr_data,
	// Read port
	input wire [2:0] rd_addr,
	output reg [15:0] rd_data
);

	reg [15:0] mem [0:7];

	always @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= 16'h0000;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule // acs_buf_mem

`default_nettype wire

/* src/acs_conv_unit.v */
// Converter clock divider and sample/convert sequencing of one conversion
`default_nettype none
`include "acs_map.vh"

module acs_conv_unit (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Sequencer side
	input wire go,
	input wire abort,
	input wire long_sample,
	output reg busy,
	output reg done,
	output reg [11:0] result,
	// Converter core side
	output reg conv_clk_tick,
	output reg sampling,
	output reg conv_trigger,
	input wire [11:0] core_result,
	input wire core_valid
);

	localparam ST_IDLE = 2'b00;
	localparam ST_SAMPLE = 2'b01;
	localparam ST_CONV = 2'b10;

	reg [1:0] state;
	reg [3:0] div_cnt;
	reg [5:0] smp_cnt;
	wire tick = (div_cnt == `ACS_CLK_DIV - 4'h1);
	wire [5:0] smp_limit = long_sample ? `ACS_SAMPLE_LONG : `ACS_SAMPLE_SHORT;

	// ****************************************
	// Converter clock enable
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 4'h0;
			conv_clk_tick <= 1'b0;
		end else begin
			div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
			conv_clk_tick <= tick;
		end
	end

	// ****************************************
	// Sample and convert
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			smp_cnt <= 6'h00;
			busy <= 1'b0;
			done <= 1'b0;
			sampling <= 1'b0;
			conv_trigger <= 1'b0;
			result <= 12'h000;
		end else begin
			done <= 1'b0;
			conv_trigger <= 1'b0;
			if (abort) begin
				state <= ST_IDLE;
				busy <= 1'b0;
				sampling <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						if (go) begin
							state <= ST_SAMPLE;
							smp_cnt <= 6'h00;
							busy <= 1'b1;
							sampling <= 1'b1;
						end
					end
					ST_SAMPLE: begin
						if (tick) begin
							smp_cnt <= smp_cnt + 6'h01;
							if (smp_cnt == smp_limit - 6'h01) begin
								sampling <= 1'b0;
								conv_trigger <= 1'b1;
								state <= ST_CONV;
							end
						end
					end
					ST_CONV: begin
						if (core_valid) begin
							result <= core_result;
							done <= 1'b1;
							busy <= 1'b0;
							state <= ST_IDLE;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule // acs_conv_unit

`default_nettype wire

/* sim/acs_core_model.sv */
// Behavioural converter core answering each conversion trigger
`default_nettype none
module acs_core_model #(parameter int DELAY = 6) (
	// Clock
	input wire logic pclk,
	// Converter link
	input wire logic [3:0] conv_channel,
	input wire logic conv_trigger,
	output logic [11:0] core_result,
	output logic core_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial begin
		core_result = 12'hFFF;
		core_valid = 1'b0;
	end
	// Result is channel in the top nibble; bus toggles while idle
	always @(posedge pclk) begin
		core_valid <= 1'b0;
		core_result <= ~core_result;
		if (conv_trigger)
			cnt <= DELAY;
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (cnt == 1 && !conv_trigger) begin
			core_valid <= 1'b1;
			core_result <= {conv_channel, 8'hC6};
		end
	end
endmodule // acs_core_model
`default_nettype wire

/* sim/acs_seq_monitor.sv */
// Port assertions for the ADC conversion sequencer
`default_nettype none
module acs_seq_monitor (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Converter
	input wire logic converter_power,
	input wire logic conv_clk_tick,
	input wire logic conv_sampling,
	input wire logic conv_trigger
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_end = psel && penable && pready && !pwrite;
	chk_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	chk_err_qual: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_err_zero: assert property (rd_end && pslverr |-> prdata == 32'h0)
		else $error("refused read not zero");
	chk_upper_zero: assert property (rd_end |-> prdata[31:8] == 24'h0)
		else $error("read upper bits not zero");
	chk_trig_pulse: assert property (conv_trigger |=> !conv_trigger)
		else $error("trigger longer than one cycle");
	chk_tick_gap: assert property (conv_clk_tick |=> !conv_clk_tick [*3])
		else $error("converter tick too close");
	chk_sample_min: assert property ($fell(conv_sampling) && conv_trigger |-> $past(conv_sampling, 4))
		else $error("sampling shorter than two ticks");
	chk_sample_end: assert property ($rose(conv_sampling) |-> ##[4:140] (conv_trigger || !conv_sampling))
		else $error("no trigger after sampling");
	chk_power_gate: assert property (conv_sampling |-> converter_power)
		else $error("sampling while converter off");
	cover property (conv_trigger);
	cover property (pready && pslverr);
	cover property ($fell(converter_power));
endmodule // acs_seq_monitor
bind acs_seq_top acs_seq_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
	.pready, .pslverr, .converter_power, .conv_clk_tick, .conv_sampling, .conv_trigger);
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the ADC conversion sequencer
`default_nettype none
`include "acs_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, converter_power, conv_clk_tick, conv_sampling;
	logic conv_trigger, core_valid;
	logic [3:0] conv_channel;
	logic [11:0] core_result;
	logic [15:0] ex;
	int bad_count = 0;
	int total_checks = 0;
	int i, n;
	always #2.5 pclk = ~pclk;
	acs_seq_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .converter_power, .conv_channel, .conv_clk_tick, .conv_sampling,
		.conv_trigger, .core_result, .core_valid);
	acs_core_model #(.DELAY(3)) u_core (.pclk, .conv_channel, .conv_trigger, .core_result,
		.core_valid);
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Look at pready mid-cycle so the request still stands at the sampling edge
		for (k = 0; k < 20; k++) begin
			@(negedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			chk(32'h0, 32'h1);
			finish_test();
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, {24'h0, exp});
	endtask
	task automatic wait_flag();
		for (int k = 0; k < 300; k++) begin
			apb(1'b0, `ACS_OFF_CTRL0, 32'h0);
			if (rd[`ACS_CTRL0_FLAG] === 1'b1)
				return;
		end
		chk(32'h0, 32'h1);
		finish_test();
	endtask
	// Expected {high, low} result bytes for length and justify choices
	function automatic logic [15:0] place(input logic [11:0] r, input logic len, just);
		if (!len)
			return just ? {4'h0, r} : {r[11:4], 4'h0, r[3:0]};
		return just ? {6'h0, r[11:2]} : {r[11:4], 6'h0, r[3:2]};
	endfunction
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`ACS_OFF_RES_HIGH, 8'h00);
		rdc(`ACS_OFF_MODE, 8'h00);
		apb(1'b1, `ACS_OFF_RES_LOW, 32'hA5);
		rdc(`ACS_OFF_RES_LOW, 8'hA5);
		apb(1'b0, 8'h3C, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("registers done");
		for (i = 0; i < 4; i++) begin
			apb(1'b1, `ACS_OFF_CTRL2, {24'h0, i[1:0], 6'h00});
			apb(1'b1, `ACS_OFF_CHAN, 32'(i + 3));
			apb(1'b1, `ACS_OFF_CTRL0, 32'hC0);
			wait_flag();
			chk({31'h0, rd[`ACS_CTRL0_START]}, 32'h0);
			ex = place({4'(i + 3), 8'hC6}, i[1], i[0]);
			rdc(`ACS_OFF_RES_HIGH, ex[15:8]);
			rdc(`ACS_OFF_RES_LOW, ex[7:0]);
			apb(1'b1, `ACS_OFF_CTRL0, 32'hE0);
			rdc(`ACS_OFF_CTRL0, 8'hA0);
			apb(1'b1, `ACS_OFF_CTRL0, 32'h80);
		end
		$display("single done");
		apb(1'b1, `ACS_OFF_CTRL2, 32'h0);
		apb(1'b1, `ACS_OFF_SLOT0, 32'h21);
		apb(1'b1, `ACS_OFF_SLOT1, 32'h43);
		apb(1'b1, `ACS_OFF_SLOT2, 32'h65);
		apb(1'b1, `ACS_OFF_SLOT3, 32'h87);
		apb(1'b1, `ACS_OFF_MODE, 32'h17);
		apb(1'b1, `ACS_OFF_CTRL0, 32'hC0);
		wait_flag();
		for (i = 0; i < 8; i++) begin
			rdc(8'(64 + 8 * i), {4'(i + 1), 4'hC});
			rdc(8'(68 + 8 * i), 8'h06);
		end
		apb(1'b1, `ACS_OFF_CTRL0, 32'h80);
		$display("scan done");
		apb(1'b1, `ACS_OFF_CHAN, 32'h9);
		apb(1'b1, `ACS_OFF_MODE, 32'h61);
		apb(1'b1, `ACS_OFF_CTRL0, 32'hC0);
		wait_flag();
		rdc(8'h40, 8'h9C);
		rdc(8'h48, 8'h9C);
		rdc(8'h50, 8'h3C);
		apb(1'b1, `ACS_OFF_CTRL0, 32'h80);
		$display("buffered done");
		apb(1'b1, `ACS_OFF_CHAN, 32'h2);
		apb(1'b1, `ACS_OFF_MODE, 32'h20);
		apb(1'b1, `ACS_OFF_CTRL0, 32'hC0);
		wait_flag();
		apb(1'b1, `ACS_OFF_CTRL0, 32'hC0);
		wait_flag();
		rdc(`ACS_OFF_RES_HIGH, 8'h2C);
		apb(1'b1, `ACS_OFF_MODE, 32'h31);
		apb(1'b1, `ACS_OFF_CTRL0, 32'h80);
		apb(1'b1, `ACS_OFF_CTRL0, 32'hC0);
		wait_flag();
		apb(1'b1, `ACS_OFF_CTRL0, 32'hC0);
		wait_flag();
		rdc(8'h48, 8'h2C);
		apb(1'b1, `ACS_OFF_CTRL0, 32'h00);
		apb(1'b1, `ACS_OFF_CTRL0, 32'h00);
		rdc(`ACS_OFF_CTRL0, 8'h00);
		$display("repeat done");
		apb(1'b1, `ACS_OFF_MODE, 32'h1F);
		apb(1'b1, `ACS_OFF_CTRL0, 32'hC0);
		for (n = 0; n < 50 && conv_sampling !== 1'b1; n++)
			@(posedge pclk);
		for (n = 0; n < 200 && conv_sampling === 1'b1; n++)
			@(posedge pclk);
		chk({31'h0, n > 100 && n < 140}, 32'h1);
		apb(1'b1, `ACS_OFF_CTRL0, 32'h00);
		repeat (50) @(posedge pclk);
		chk({31'h0, conv_sampling}, 32'h0);
		rdc(`ACS_OFF_CTRL0, 8'h00);
		$display("abort done");
		finish_test();
	end
endmodule // testbench
`default_nettype wire
